// *** rtl/duc_pkg.sv ***
// Shared constants for the converter update and reset control block.
// Assumes a single 25 MHz system clock; registers sit behind a parallel bus, strobe, clear and straps are ports.
package duc_pkg;
   localparam int DUC_CHANNELS = 8;
   localparam int DUC_DATA_W = 14;
   localparam int DUC_ADDR_W = 5;
   localparam int DUC_MON_W = 4;
   // Reset values
   localparam logic [13:0] DUC_RST_ZERO_CODE = 14'h0000;
   localparam logic [13:0] DUC_RST_MID_CODE = 14'h2000;
   localparam logic [13:0] DUC_RST_OFS_USB = 14'h2666;
   localparam logic [13:0] DUC_RST_OFS_BTC = 14'h0666;
   localparam logic [13:0] DUC_RST_GAIN = 14'h2000;
   localparam logic [13:0] DUC_RST_ZEROREG = 14'h0000;
   localparam logic [13:0] DUC_RST_INPUT = 14'h0000;
   // Address map of the parallel bus
   localparam logic [4:0] DUC_ADDR_CFG = 5'h00;
   localparam logic [4:0] DUC_ADDR_MON = 5'h01;
   localparam logic [4:0] DUC_ADDR_GPIO = 5'h02;
   localparam logic [4:0] DUC_ADDR_OFSA = 5'h03;
   localparam logic [4:0] DUC_ADDR_OFSB = 5'h04;
   localparam logic [1:0] DUC_ADDR_DAC_TOP = 2'h1;
   localparam logic [1:0] DUC_ADDR_ZERO_TOP = 2'h2;
   localparam logic [1:0] DUC_ADDR_GAIN_TOP = 2'h3;
   // Configuration field positions
   localparam int DUC_CFG_RDSEL = 13;
   localparam int DUC_CFG_LD = 12;
   localparam int DUC_CFG_SWRST = 11;
   localparam int DUC_CFG_CE = 8;
   localparam int DUC_CFG_BUSY = 7;
   localparam int DUC_GPIO_BIT = 13;
   // Monitor select codes: channel 0..7, then offset A/B, reference A/B
   localparam logic [3:0] DUC_MON_OFSA = 4'h8;
   localparam logic [3:0] DUC_MON_OFSB = 4'h9;
   localparam logic [3:0] DUC_MON_REFA = 4'hA;
   localparam logic [3:0] DUC_MON_REFB = 4'hB;
   // Correction engine spends this many calculate cycles per channel, then one write cycle
   localparam int DUC_CORR_CYCLES = 4;
   typedef enum logic [1:0] {DUC_ENG_IDLE, DUC_ENG_CALC, DUC_ENG_WRITE} duc_eng_e;
endpackage

// *** rtl/duc_corr_if.sv ***
// Carries a correction request and its result between the control block and the engine.
// Assumes both ends share clk_sys.
`timescale 1ns/1ns
interface duc_corr_if;
   logic req;
   logic [2:0] chan;
   logic [13:0] input_code;
   logic [13:0] gain_code;
   logic [13:0] zero_code;
   logic busy;
   logic done;
   logic [2:0] done_chan;
   logic [13:0] result;
   modport ctrl (output req, output chan, output input_code, output gain_code, output zero_code,
      input busy, input done, input done_chan, input result);
   modport eng (input req, input chan, input input_code, input gain_code, input zero_code,
      output busy, output done, output done_chan, output result);
endinterface

// *** rtl/duc_corr_engine.sv ***
// Calibration correction engine: one channel at a time, fixed latency.
// Assumes requests arrive only while busy is low.
`timescale 1ns/1ns
module duc_corr_engine
   import duc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   duc_corr_if.eng cor
);
   duc_eng_e state_reg;
   logic [2:0] cnt_reg;
   logic [2:0] chan_reg;
   logic [13:0] res_reg;
   logic [27:0] prod;
   logic [13:0] scaled;
   // Result = input*(gain+2^13)/2^14 + zero, wrapped to 14 bits
   assign prod = 28'(cor.input_code) * 28'({1'b0, cor.gain_code} + 15'h2000);
   assign scaled = prod[27:14];
   assign cor.busy = (state_reg != DUC_ENG_IDLE);
   assign cor.done = (state_reg == DUC_ENG_WRITE);
   assign cor.done_chan = chan_reg;
   assign cor.result = res_reg;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= DUC_ENG_IDLE;
         cnt_reg <= 3'h0;
         chan_reg <= 3'h0;
         res_reg <= 14'h0000;
      end
      else
      begin
         unique case (state_reg)
            DUC_ENG_IDLE:
               if (cor.req)
               begin
                  state_reg <= DUC_ENG_CALC;
                  cnt_reg <= 3'(DUC_CORR_CYCLES - 1);
                  chan_reg <= cor.chan;
                  res_reg <= scaled + cor.zero_code;
               end
            DUC_ENG_CALC:
               if (cnt_reg == 3'h0)
                  state_reg <= DUC_ENG_WRITE;
               else
                  cnt_reg <= cnt_reg - 3'h1;
            DUC_ENG_WRITE:
               state_reg <= DUC_ENG_IDLE;
         endcase
      end
   end
endmodule

// *** rtl/duc_top.sv ***
// Update, clear and reset control of an eight-channel converter behind a parallel bus.
// Assumes bus strobes are synchronous to clk_sys; analog parts see the latch and enable outputs.
// What this block does
// - Output-mode pin floats when its bit is 1, drives low when 0.
// - Reading the pin bit returns the level present on the pin.
// - Any reset sets the pin bit to 1, pin floating.
// - While correction runs, busy flag set and busy output pulled low.
// - Busy output released once data register updates are finished.
// - Clear low forces all outputs to cleared state, buffers high impedance.
// - Load strobe pulses during clear low are ignored.
// - Synchronous mode: clear rising with strobe high keeps outputs cleared until strobe next falls.
// - Strobe held low: outputs restored to latch values when clear rises.
// - Clear leaves zero, gain, input, data registers and latches unchanged.
// - Reset loads data registers and latches with 0000h or 2000h by select and format.
// - Reset loads offset registers with 2666h straight binary or 0666h twos complement.
// - Power-on and hardware reset clear input registers to 0000h.
// - During reset input low, bus ignored and data bus high impedance.
// - After reset, outputs hold reset values and bus resumes.
// - Load mode captured at power-on from strobe level; host holds it.
// - Load reloads only channels written since previous load event.
// - Asynchronous mode: strobe ignored; latch updates on chip-select rise or engine write.
// - Synchronous mode: strobe fall or load bit updates written channels, waiting for busy clear.
// - Monitor routes selected source; high impedance when disabled.
// - Engine runs only with correction enabled; else data passes directly.
// - Reset loads gain registers with 8192 and zero registers with zero.
// - Load bit clears itself after a synchronous update.
`timescale 1ns/1ns
module duc_top
   import duc_pkg::*;
#(
   parameter int CHANNELS = DUC_CHANNELS
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic chip_select_n,
   input wire logic read_write,
   input wire logic [DUC_ADDR_W-1:0] address_lines,
   input wire logic [DUC_DATA_W-1:0] data_bus_in,
   output logic [DUC_DATA_W-1:0] data_bus_out,
   output logic data_bus_oe,
   input wire logic load_strobe_n,
   input wire logic output_clear_n,
   input wire logic reset_level_select,
   input wire logic code_format_select,
   input wire logic gpio_in,
   output logic gpio_out,
   output logic gpio_oe,
   output logic busy_out,
   output logic busy_oe,
   output logic [DUC_DATA_W*CHANNELS-1:0] latch_codes,
   output logic [DUC_DATA_W-1:0] offset_a_code,
   output logic [DUC_DATA_W-1:0] offset_b_code,
   output logic outputs_cleared,
   output logic [DUC_MON_W-1:0] monitor_select,
   output logic monitor_enable
);
   duc_corr_if cor();
   duc_corr_engine u_eng (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .cor(cor)
   );

   // ==========================================================
   // Storage
   logic [13:0] input_reg [CHANNELS];
   logic [13:0] data_reg [CHANNELS];
   logic [13:0] latch_reg [CHANNELS];
   logic [13:0] gain_reg [CHANNELS];
   logic [13:0] zero_reg [CHANNELS];
   logic [13:0] ofs_a_reg;
   logic [13:0] ofs_b_reg;
   logic [CHANNELS-1:0] touched_reg;
   logic [CHANNELS-1:0] pend_reg;
   logic rdsel_reg;
   logic ld_reg;
   logic ce_reg;
   logic gpio_reg;
   logic [13:0] mon_reg;
   logic sync_mode_reg;
   logic mode_taken_reg;
   logic cs_d_reg;
   logic ld_n_d_reg;
   logic clr_hold_reg;
   logic sync_wait_reg;
   logic swrst_reg;
   logic [13:0] rd_reg;

   // ==========================================================
   // Decode
   logic cs_rise;
   logic wr_now;
   logic [4:0] a_held;
   logic a_is_dac;
   logic a_is_zero;
   logic a_is_gain;
   logic [2:0] a_ch;
   logic strobe_fall;
   logic load_evt;
   logic do_sync;
   logic [13:0] rst_code;
   logic [13:0] rst_ofs;
   logic soft_rst;
   logic [2:0] pend_ch;
   logic pend_any;

   // Address and data are sampled at the first clock edge after chip-select rises
   assign cs_rise = chip_select_n && !cs_d_reg;
   assign wr_now = cs_rise && !read_write;
   assign a_held = address_lines;
   assign a_ch = a_held[2:0];
   assign a_is_dac = (a_held[4:3] == DUC_ADDR_DAC_TOP);
   assign a_is_zero = (a_held[4:3] == DUC_ADDR_ZERO_TOP);
   assign a_is_gain = (a_held[4:3] == DUC_ADDR_GAIN_TOP);
   // Strobe edges during clear are dropped
   assign strobe_fall = !load_strobe_n && ld_n_d_reg && output_clear_n;
   assign load_evt = sync_mode_reg && (strobe_fall || (wr_now && a_held == DUC_ADDR_CFG
      && data_bus_in[DUC_CFG_LD]));
   // Waits for busy clear before updating
   assign do_sync = (load_evt || sync_wait_reg) && !cor.busy && !pend_any && !wr_now;
   // Reset code table
   assign rst_code = (reset_level_select ^ code_format_select) ? DUC_RST_MID_CODE : DUC_RST_ZERO_CODE;
   assign rst_ofs = code_format_select ? DUC_RST_OFS_BTC : DUC_RST_OFS_USB;
   assign soft_rst = swrst_reg;
   assign pend_any = |pend_reg;
   always_comb
   begin
      pend_ch = 3'h0;
      for (int i = CHANNELS - 1; i >= 0; i--)
         if (pend_reg[i])
            pend_ch = 3'(i);
   end

   assign cor.req = pend_any && !cor.busy && ce_reg;
   assign cor.chan = pend_ch;
   assign cor.input_code = input_reg[pend_ch];
   assign cor.gain_code = gain_reg[pend_ch];
   assign cor.zero_code = zero_reg[pend_ch];

   // ==========================================================
   // Load mode capture at power-on
   // Strap taken on the first clock after reset release
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_taken_reg <= 1'b0;
         sync_mode_reg <= 1'b0;
      end
      else if (!mode_taken_reg)
      begin
         mode_taken_reg <= 1'b1;
         sync_mode_reg <= load_strobe_n;
      end
   end

   // ==========================================================
   // Edge history and clear hold
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cs_d_reg <= 1'b1;
         ld_n_d_reg <= 1'b1;
         clr_hold_reg <= 1'b0;
      end
      else
      begin
         cs_d_reg <= chip_select_n;
         ld_n_d_reg <= load_strobe_n;
         if (!output_clear_n)
            clr_hold_reg <= sync_mode_reg;
         else if (!load_strobe_n)
            clr_hold_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdsel_reg <= 1'b1;
         ld_reg <= 1'b0;
         ce_reg <= 1'b0;
         gpio_reg <= 1'b1;
         mon_reg <= 14'h0000;
         swrst_reg <= 1'b0;
         sync_wait_reg <= 1'b0;
      end
      else if (soft_rst)
      begin
         rdsel_reg <= 1'b1;
         ld_reg <= 1'b0;
         ce_reg <= 1'b0;
         gpio_reg <= 1'b1;
         mon_reg <= 14'h0000;
         swrst_reg <= 1'b0;
         sync_wait_reg <= 1'b0;
      end
      else
      begin
         if (wr_now && a_held == DUC_ADDR_CFG)
         begin
            rdsel_reg <= data_bus_in[DUC_CFG_RDSEL];
            ce_reg <= data_bus_in[DUC_CFG_CE];
            swrst_reg <= data_bus_in[DUC_CFG_SWRST];
            ld_reg <= data_bus_in[DUC_CFG_LD] && sync_mode_reg;
         end
         else if (do_sync)
            ld_reg <= 1'b0;
         if (wr_now && a_held == DUC_ADDR_GPIO)
            gpio_reg <= data_bus_in[DUC_GPIO_BIT];
         if (wr_now && a_held == DUC_ADDR_MON)
            mon_reg <= data_bus_in;
         if (do_sync)
            sync_wait_reg <= 1'b0;
         else if (load_evt)
            sync_wait_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Channel registers; clear input touches none of them
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            input_reg[i] <= DUC_RST_INPUT;
            data_reg[i] <= 14'h0000;
            latch_reg[i] <= 14'h0000;
            gain_reg[i] <= DUC_RST_GAIN;
            zero_reg[i] <= DUC_RST_ZEROREG;
         end
         ofs_a_reg <= 14'h0000;
         ofs_b_reg <= 14'h0000;
         touched_reg <= '0;
         pend_reg <= '0;
      end
      else if (!mode_taken_reg || soft_rst)
      begin
         // Straps loaded a cycle after release since async reset takes constants only
         for (int i = 0; i < CHANNELS; i++)
         begin
            input_reg[i] <= DUC_RST_INPUT;
            data_reg[i] <= rst_code;
            latch_reg[i] <= rst_code;
            gain_reg[i] <= DUC_RST_GAIN;
            zero_reg[i] <= DUC_RST_ZEROREG;
         end
         ofs_a_reg <= rst_ofs;
         ofs_b_reg <= rst_ofs;
         touched_reg <= '0;
         pend_reg <= '0;
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (wr_now && a_is_dac && a_ch == 3'(i))
            begin
               input_reg[i] <= data_bus_in;
               if (ce_reg)
                  pend_reg[i] <= 1'b1;
               else
               begin
                  data_reg[i] <= data_bus_in;
                  if (!sync_mode_reg)
                     latch_reg[i] <= data_bus_in;
               end
               if (sync_mode_reg)
                  touched_reg[i] <= 1'b1;
            end
            if (cor.done && cor.done_chan == 3'(i))
            begin
               data_reg[i] <= cor.result;
               if (!sync_mode_reg)
                  latch_reg[i] <= cor.result;
            end
            if (cor.req && !cor.busy && pend_ch == 3'(i) && !(wr_now && a_is_dac && a_ch == 3'(i)))
               pend_reg[i] <= 1'b0;
            if (wr_now && a_is_zero && a_ch == 3'(i))
               zero_reg[i] <= data_bus_in;
            if (wr_now && a_is_gain && a_ch == 3'(i))
               gain_reg[i] <= data_bus_in;
            if (do_sync && touched_reg[i])
            begin
               latch_reg[i] <= data_reg[i];
               touched_reg[i] <= 1'b0;
            end
         end
         if (wr_now && a_held == DUC_ADDR_OFSA)
            ofs_a_reg <= data_bus_in;
         if (wr_now && a_held == DUC_ADDR_OFSB)
            ofs_b_reg <= data_bus_in;
      end
   end

   // ==========================================================
   // Read path
   logic [13:0] rd_next;
   always_comb
   begin
      rd_next = 14'h0000;
      if (a_held == DUC_ADDR_CFG)
      begin
         rd_next[DUC_CFG_RDSEL] = rdsel_reg;
         rd_next[DUC_CFG_LD] = ld_reg;
         rd_next[DUC_CFG_CE] = ce_reg;
         rd_next[DUC_CFG_BUSY] = cor.busy || pend_any;
      end
      else if (a_held == DUC_ADDR_MON)
         rd_next = {mon_reg[13:2], 2'b00};
      else if (a_held == DUC_ADDR_GPIO)
         rd_next[DUC_GPIO_BIT] = gpio_in;
      else if (a_held == DUC_ADDR_OFSA)
         rd_next = ofs_a_reg;
      else if (a_held == DUC_ADDR_OFSB)
         rd_next = ofs_b_reg;
      else if (a_is_dac)
         rd_next = rdsel_reg ? data_reg[a_ch] : input_reg[a_ch];
      else if (a_is_zero)
         rd_next = zero_reg[a_ch];
      else if (a_is_gain)
         rd_next = gain_reg[a_ch];
   end
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         rd_reg <= 14'h0000;
      else
         rd_reg <= rd_next;
   end

   // ==========================================================
   // Pins
   // Bus driven only while rst_b is high and a read is selected, so it floats throughout reset
   assign data_bus_out = rd_reg;
   assign data_bus_oe = rst_b && !chip_select_n && read_write;
   assign gpio_out = 1'b0;
   assign gpio_oe = !gpio_reg;
   assign busy_out = 1'b0;
   // Held low until every queued correction is written back
   assign busy_oe = cor.busy || pend_any;
   assign outputs_cleared = !output_clear_n || clr_hold_reg;
   assign offset_a_code = ofs_a_reg;
   assign offset_b_code = ofs_b_reg;
   // Monitor: lowest set select bit wins; none set means disabled
   logic [11:0] mon_bits;
   assign mon_bits = mon_reg[13:2];
   always_comb
   begin
      monitor_select = 4'h0;
      for (int b = 11; b >= 0; b--)
         if (mon_bits[b])
            monitor_select = (b >= 4) ? 4'(b - 4) : 4'(DUC_MON_OFSA + 4'(3 - b));
   end
   assign monitor_enable = |mon_bits;
   for (genvar g = 0; g < CHANNELS; g++)
   begin : g_latch
      assign latch_codes[g*DUC_DATA_W +: DUC_DATA_W] = latch_reg[g];
   end
endmodule

// *** dv/duc_checker_properties.sv ***
// Concurrent checks on the ports of duc_top.
// Assumes one clock domain; bound to duc_top from the bench top file.
`timescale 1ns/1ns
module duc_checker
   import duc_pkg::*;
#(
   parameter int CHANNELS = DUC_CHANNELS
)
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic chip_select_n,
   input wire logic data_bus_oe,
   input wire logic load_strobe_n,
   input wire logic output_clear_n,
   input wire logic reset_level_select,
   input wire logic code_format_select,
   input wire logic gpio_oe,
   input wire logic busy_oe,
   input wire logic [DUC_DATA_W*CHANNELS-1:0] latch_codes,
   input wire logic [DUC_DATA_W-1:0] offset_a_code,
   input wire logic [DUC_DATA_W-1:0] offset_b_code,
   input wire logic outputs_cleared
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   logic first_reg;
   logic sync_mode_reg;
   logic [DUC_DATA_W-1:0] rst_code;
   logic [DUC_DATA_W-1:0] rst_ofs;
   assign rst_code = (reset_level_select ^ code_format_select) ? DUC_RST_MID_CODE : DUC_RST_ZERO_CODE;
   assign rst_ofs = code_format_select ? DUC_RST_OFS_BTC : DUC_RST_OFS_USB;
   // Mirror of the load mode, taken at the first edge after reset like the design
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         first_reg <= 1'b1;
         sync_mode_reg <= 1'b0;
      end
      else
      begin
         first_reg <= 1'b0;
         if (first_reg)
            sync_mode_reg <= load_strobe_n;
      end
   end
   // Writes and engine results land a cycle or two late, so both are kept out of the window
   property p_frozen(cond);
      cond && chip_select_n && $past(chip_select_n) && $past(chip_select_n, 2) && $past(rst_b)
         && !busy_oe && !$past(busy_oe) && !$past(busy_oe, 2) |=> $stable(latch_codes);
   endproperty
   // ==========================================================
   // Assertions
   a_clear_forces: assert property (!output_clear_n |-> outputs_cleared)
      else $error("outputs not cleared while clear is low");
   a_clear_keeps: assert property (outputs_cleared && load_strobe_n ##1 load_strobe_n |-> outputs_cleared)
      else $error("outputs left cleared state without a strobe fall");
   a_clear_frozen: assert property (p_frozen(!output_clear_n))
      else $error("latches changed while clear is low");
   a_sync_still: assert property (p_frozen(sync_mode_reg && load_strobe_n))
      else $error("latches changed in sync mode without a load event");
   a_busy_ends: assert property ($rose(busy_oe) |-> ##[1:100] !busy_oe)
      else $error("busy output not released");
   a_reset_code: assert property ($rose(rst_b) |=> latch_codes == {CHANNELS{rst_code}})
      else $error("latches not at reset code");
   a_reset_offset: assert property ($rose(rst_b) |=> offset_a_code == rst_ofs && offset_b_code == rst_ofs)
      else $error("offset codes not at reset value");
   a_gpio_float: assert property ($rose(rst_b) |=> !gpio_oe)
      else $error("gpio pin driven after reset");
   a_bus_float: assert property (disable iff (1'b0) !rst_b || chip_select_n |-> !data_bus_oe)
      else $error("data bus driven outside a read");
   c_bus_read: cover property (data_bus_oe);
   c_sync_load: cover property (sync_mode_reg && $fell(load_strobe_n));
   c_busy: cover property ($rose(busy_oe));
   c_clear_rise: cover property ($rose(output_clear_n) && load_strobe_n);
endmodule

// *** dv/duc_host_model.sv ***
// Host processor model: drives the parallel bus, strobes, clear and reset.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
module duc_host_model
   import duc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [DUC_DATA_W-1:0] data_bus_out,
   output logic rst_b,
   output logic chip_select_n,
   output logic read_write,
   output logic [DUC_ADDR_W-1:0] address_lines,
   output logic [DUC_DATA_W-1:0] data_bus_in,
   output logic load_strobe_n,
   output logic output_clear_n
);
   initial
   begin
      rst_b = 1'b0;
      chip_select_n = 1'b1;
      read_write = 1'b0;
      address_lines = 5'h00;
      data_bus_in = 14'h0000;
      load_strobe_n = 1'b1;
      output_clear_n = 1'b1;
   end
   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic hw_reset(input logic strobe);
      step();
      chip_select_n = 1'b1;
      load_strobe_n = strobe;
      rst_b = 1'b0;
      repeat (16) step();
      rst_b = 1'b1;
      repeat (2) step();
   endtask
   task automatic access(input logic rd, input logic [4:0] a, input logic [13:0] d, output logic [13:0] q);
      step();
      chip_select_n = 1'b0;
      read_write = rd;
      address_lines = a;
      data_bus_in = d;
      step();
      chip_select_n = 1'b1;
      step();
      q = data_bus_out;
      // Released lines flip so a stale value never looks valid
      address_lines = ~a;
      data_bus_in = ~d;
      read_write = 1'b0;
   endtask
   task automatic strobe_pulse;
      step();
      load_strobe_n = 1'b0;
      step();
      load_strobe_n = 1'b1;
      step();
   endtask
endmodule

// *** dv/duc_top_tb_top.sv ***
// Self-checking bench for duc_top with the host model on its bus.
// Assumes a 25 MHz clock; the gpio pin has a pull-up.
`timescale 1ns/1ns
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module duc_top_tb_top
   import duc_pkg::*;
;
   logic clk_sys, rst_b, chip_select_n, read_write, data_bus_oe, load_strobe_n, output_clear_n;
   logic reset_level_select, code_format_select, gpio_in, gpio_out, gpio_oe, gpio_ext;
   logic busy_out, busy_oe, outputs_cleared, monitor_enable;
   logic [4:0] address_lines;
   logic [13:0] data_bus_in, data_bus_out, offset_a_code, offset_b_code, q;
   logic [111:0] latch_codes;
   logic [3:0] monitor_select;
   logic [13:0] exp_l [8];
   int err_count, comparisons, cycles;
   // Open-drain pin: pulled up unless a party pulls it low
   assign gpio_in = gpio_oe ? gpio_out : gpio_ext;
   duc_top #(.CHANNELS(8)) duc_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .chip_select_n(chip_select_n),
      .read_write(read_write), .address_lines(address_lines), .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .load_strobe_n(load_strobe_n),
      .output_clear_n(output_clear_n), .reset_level_select(reset_level_select),
      .code_format_select(code_format_select), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .busy_out(busy_out), .busy_oe(busy_oe), .latch_codes(latch_codes), .offset_a_code(offset_a_code),
      .offset_b_code(offset_b_code), .outputs_cleared(outputs_cleared), .monitor_select(monitor_select),
      .monitor_enable(monitor_enable));
   duc_host_model duc_host_model_i (.clk_sys(clk_sys), .data_bus_out(data_bus_out), .rst_b(rst_b),
      .chip_select_n(chip_select_n), .read_write(read_write), .address_lines(address_lines),
      .data_bus_in(data_bus_in), .load_strobe_n(load_strobe_n), .output_clear_n(output_clear_n));
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic end_sim;
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Run is about 200 cycles; the ceiling leaves ample margin
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         err_count++;
         end_sim();
      end
   end
   task automatic chk_lat;
      for (int i = 0; i < 8; i++)
         `CHK("latch", exp_l[i], latch_codes[14*i +: 14])
   endtask
   task automatic wr(input logic [4:0] a, input logic [13:0] d);
      duc_host_model_i.access(1'b0, a, d, q);
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [13:0] e);
      duc_host_model_i.access(1'b1, a, 14'h0000, q);
      `CHK("read", e, q)
   endtask
   task automatic do_reset(input logic s, input logic f, input logic l);
      reset_level_select = s;
      code_format_select = f;
      duc_host_model_i.hw_reset(l);
      for (int i = 0; i < 8; i++)
         exp_l[i] = (s ^ f) ? 14'h2000 : 14'h0000;
      chk_lat();
      `CHK("ofs", {2{f ? 14'h0666 : 14'h2666}}, {offset_a_code, offset_b_code})
      `CHK("gpio_oe", 1'b0, gpio_oe)
      `CHK("bus_oe", 1'b0, data_bus_oe)
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      err_count = 0;
      comparisons = 0;
      cycles = 0;
      reset_level_select = 1'b0;
      code_format_select = 1'b0;
      gpio_ext = 1'b1;
      do_reset(1'b0, 1'b0, 1'b1);
      rd_chk(DUC_ADDR_GPIO, 14'h2000);
      gpio_ext = 1'b0;
      rd_chk(DUC_ADDR_GPIO, 14'h0000);
      gpio_ext = 1'b1;
      wr(DUC_ADDR_GPIO, 14'h0000);
      `CHK("gpio_oe", 1'b1, gpio_oe)
      rd_chk(DUC_ADDR_GPIO, 14'h0000);
      wr(DUC_ADDR_GPIO, 14'h2000);
      `CHK("gpio_oe", 1'b0, gpio_oe)
      for (int j = 0; j < 12; j++)
      begin
         wr(DUC_ADDR_MON, 14'h0001 << ((j < 8) ? 6 + j : 13 - j));
         `CHK("mon_sel", j[3:0], monitor_select)
         `CHK("mon_en", 1'b1, monitor_enable)
      end
      wr(DUC_ADDR_MON, 14'h0000);
      `CHK("mon_en", 1'b0, monitor_enable)
      wr(5'h08, 14'h1234);
      wr(5'h0B, 14'h0ABC);
      chk_lat();
      duc_host_model_i.strobe_pulse();
      exp_l[0] = 14'h1234;
      exp_l[3] = 14'h0ABC;
      chk_lat();
      wr(5'h09, 14'h0321);
      wr(DUC_ADDR_CFG, 14'h3000);
      exp_l[1] = 14'h0321;
      duc_host_model_i.step();
      chk_lat();
      rd_chk(DUC_ADDR_CFG, 14'h2000);
      // A strobe during clear is dropped but the written channel stays pending
      wr(5'h0A, 14'h0777);
      duc_host_model_i.output_clear_n = 1'b0;
      duc_host_model_i.step();
      `CHK("cleared", 1'b1, outputs_cleared)
      duc_host_model_i.strobe_pulse();
      chk_lat();
      duc_host_model_i.output_clear_n = 1'b1;
      duc_host_model_i.step();
      `CHK("cleared", 1'b1, outputs_cleared)
      chk_lat();
      duc_host_model_i.strobe_pulse();
      exp_l[2] = 14'h0777;
      `CHK("cleared", 1'b0, outputs_cleared)
      chk_lat();
      wr(DUC_ADDR_CFG, 14'h2100);
      wr(5'h0C, 14'h0155);
      duc_host_model_i.step();
      `CHK("busy_oe", 1'b1, busy_oe)
      `CHK("busy_pin", 1'b0, busy_out)
      duc_host_model_i.strobe_pulse();
      chk_lat();
      for (int k = 0; k < 50 && busy_oe === 1'b1; k++)
         duc_host_model_i.step();
      `CHK("busy_oe", 1'b0, busy_oe)
      duc_host_model_i.step();
      exp_l[4] = 14'h0155;
      chk_lat();
      wr(DUC_ADDR_CFG, 14'h2000);
      do_reset(1'b1, 1'b1, 1'b1);
      do_reset(1'b0, 1'b1, 1'b1);
      do_reset(1'b1, 1'b0, 1'b0);
      wr(5'h0D, 14'h0ABC);
      exp_l[5] = 14'h0ABC;
      chk_lat();
      duc_host_model_i.output_clear_n = 1'b0;
      duc_host_model_i.step();
      duc_host_model_i.output_clear_n = 1'b1;
      duc_host_model_i.step();
      `CHK("cleared", 1'b0, outputs_cleared)
      wr(DUC_ADDR_GPIO, 14'h0000);
      wr(DUC_ADDR_CFG, 14'h0800);
      duc_host_model_i.step();
      exp_l[5] = 14'h2000;
      chk_lat();
      `CHK("gpio_oe", 1'b0, gpio_oe)
      wr(DUC_ADDR_CFG, 14'h0000);
      rd_chk(5'h08, 14'h0000);
      end_sim();
   end
endmodule
bind duc_top duc_checker #(.CHANNELS(CHANNELS)) duc_checker_i (.clk_sys(clk_sys), .rst_b(rst_b),
   .chip_select_n(chip_select_n), .data_bus_oe(data_bus_oe), .load_strobe_n(load_strobe_n),
   .output_clear_n(output_clear_n),
   .reset_level_select(reset_level_select), .code_format_select(code_format_select), .gpio_oe(gpio_oe),
   .busy_oe(busy_oe), .latch_codes(latch_codes), .offset_a_code(offset_a_code),
   .offset_b_code(offset_b_code), .outputs_cleared(outputs_cleared));
